// *** core/lsfp_pkg.sv ***
/*
  Constants for the strap, indicator and receive pin logic.
  Assumes a 10 MHz bus clock; byte address of a register is four times its index.
*/
package lsfp_pkg;
  // Bus clock
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Register indices
  localparam logic [7:0] BASIC_CTRL_IDX  = 8'h00;
  localparam logic [7:0] VENDOR_CTRL_IDX = 8'h1e;
  localparam logic [7:0] STRAP_STAT_IDX  = 8'h1f;
  // Field positions
  localparam int unsigned SPEED_SEL_BIT = 13;
  localparam int unsigned IND_FIELD_HI  = 15;
  localparam int unsigned IND_FIELD_LO  = 14;
  localparam int unsigned RMII_MODE_BIT = 0;
  localparam int unsigned ST_FIBER_BIT  = 0;
  localparam int unsigned ST_FEF_BIT    = 1;
  localparam int unsigned ST_SD_BIT     = 2;
  localparam int unsigned ST_DONE_BIT   = 3;
  localparam int unsigned ST_ACT_BIT    = 4;
  // Reset values
  localparam logic [15:0] BASIC_CTRL_RST  = 16'h2000;
  localparam logic [15:0] VENDOR_CTRL_RST = 16'h0000;
  // Indicator functions
  localparam logic [1:0] IND_RATE    = 2'h0;
  localparam logic [1:0] IND_TRAFFIC = 2'h1;
  // Timing
  localparam int unsigned STRAP_SETTLE_CYC = 3;
  localparam int unsigned BLINK_HALF_US    = 50000;
  localparam int unsigned BLINK_HALF_CYC   = (BLINK_HALF_US * 1000) / CLK_PERIOD_NS;
endpackage

// *** core/lsfp_rx_link.sv ***
/*
  Receive pins toward the MAC, on the receive or reference clock.
  Assumes core_valid and core_data come from logic on rx_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module lsfp_rx_link (
  // Link clock and chip reset
  input  wire logic       rx_clk,
  input  wire logic       hresetn,
  // Mode from bus domain
  input  wire logic       rmii_mode,
  // Recovered data from the core
  input  wire logic       core_valid,
  input  wire logic [3:0] core_data,
  // Pins to MAC
  output logic      [3:0] rxd,
  output logic            rx_dv,
  // Activity event toward bus domain
  output logic            act_toggle
);
  logic rst_n;
  logic rmii_s;
  logic [3:0] rxd_next;
  logic dv_next;
  logic tgl_next;

  // Local reset, released on rx_clk
  lsfp_sync2 #(.WIDTH(1)) u_rst (.clk(rx_clk), .rst_n(hresetn), .d(1'b1), .q(rst_n));
  lsfp_sync2 #(.WIDTH(1)) u_mode (.clk(rx_clk), .rst_n(rst_n), .d(rmii_mode), .q(rmii_s));

  // Nibble or dibit, zero outside a valid cycle
  always_comb
  begin
    dv_next  = core_valid;
    rxd_next = 4'h0;
    if (core_valid)
      rxd_next = rmii_s ? {2'h0, core_data[1:0]} : core_data;
    tgl_next = act_toggle ^ (core_valid & ~rx_dv);
  end

  always_ff @(posedge rx_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxd        <= 4'h0;
      rx_dv      <= 1'b0;
      act_toggle <= 1'b0;
    end
    else
    begin
      rxd        <= rxd_next;
      rx_dv      <= dv_next;
      act_toggle <= tgl_next;
    end
  end

  invalid_zero_a: assert property (@(posedge rx_clk) disable iff (!rst_n)
    !rx_dv |-> rxd == 4'h0) else $error("rxd not zero while rx_dv low");
  nibble_path_a: assert property (@(posedge rx_clk) disable iff (!rst_n)
    core_valid && !rmii_s |=> rx_dv && rxd == $past(core_data))
    else $error("nibble not passed");
  dibit_path_a: assert property (@(posedge rx_clk) disable iff (!rst_n)
    core_valid && rmii_s |=> rx_dv && rxd == {2'h0, $past(core_data[1:0])})
    else $error("dibit not passed");
endmodule // lsfp_rx_link
`default_nettype wire

// *** core/lsfp_sync2.sv ***
/*
  Two flip-flop synchroniser for levels.
  Assumes d is static long enough to be caught by clk.
*/
`timescale 1ns/1ps
`default_nettype none
module lsfp_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Level in and out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // Two stages, only the second is read outside
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // lsfp_sync2
`default_nettype wire

// *** core/lsfp_top.sv ***
/*
  Shared indicator pin with strap sampling, fiber select pin,
  receive pins toward the MAC and an AHB-Lite register slave.
  Assumes pins are asynchronous to hclk; rx_clk is unrelated to hclk.
*/
// What this block does
// - Copper: strap loads speed select bit
// - Fiber: strap is far-end-fault enable
// - Indicator function from vendor register field
// - Field 00 rate, 01 traffic, others reserved
// - Low fiber pin means copper
// - Fiber mode: pin is signal detect
// - Strap pin input in reset and until sampled, output after
// - MII nibble driven on receive clock
// - Receive data valid only with valid flag
// - RMII dibit driven on reference clock
// - RMII two bits per valid clock
// - Speed strap high 100, low 10
// - Fault strap high enables, low disables
`timescale 1ns/1ps
`default_nettype none
module lsfp_top #(
  parameter int unsigned BLINK_CYC = lsfp_pkg::BLINK_HALF_CYC
) (
  // Bus clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Shared indicator and strap pin
  input  wire logic        ind_pin_in,
  output logic             ind_pin_out,
  output logic             ind_pin_oe_n,
  // Fiber enable and signal detect pin
  input  wire logic        fiber_pin_in,
  // Receive side
  input  wire logic        rx_clk,
  input  wire logic        core_valid,
  input  wire logic [3:0]  core_data,
  output logic      [3:0]  rxd,
  output logic             rx_dv
);
  localparam int CW = $clog2(BLINK_CYC + 1);
  localparam logic [CW-1:0] BLINK_LAST = CW'(BLINK_CYC - 1);
  localparam logic [1:0] IND_RATE_C    = lsfp_pkg::IND_RATE;
  localparam logic [1:0] IND_TRAFFIC_C = lsfp_pkg::IND_TRAFFIC;

  // Refuse a blink period the counter cannot serve
  if (BLINK_CYC < 2)
  begin : g_blink_chk
    $error("BLINK_CYC must be at least 2");
  end

  typedef enum logic [0:0] {PH_STRAP, PH_RUN} lsfp_phase_t;

  // Word index of a word-aligned address, all ones when unmapped
  function automatic logic [7:0] reg_index(input logic [31:0] a);
    reg_index = (a[31:10] == 22'h0 && a[1:0] == 2'h0) ? a[9:2] : 8'hff;
  endfunction

  logic        ind_s;
  logic        fiber_s;
  logic        act_s;
  logic        act_d_reg;
  logic        act_evt;
  logic        rmii_mode;
  logic        act_toggle_w;

  logic        wr_pend_reg, wr_pend_next;
  logic [7:0]  wr_idx_reg, wr_idx_next;
  logic [31:0] hrdata_next;
  logic [15:0] basic_reg, basic_next;
  logic [15:0] vendor_reg, vendor_next;
  logic [7:0]  rd_idx;
  logic        addr_ok;

  lsfp_phase_t phase_reg, phase_next;
  logic [1:0]  settle_reg, settle_next;
  logic        capture;
  logic        fiber_mode_reg, fiber_mode_next;
  logic        fef_en_reg, fef_en_next;
  logic        sig_det;
  logic [CW-1:0] blink_cnt_reg, blink_cnt_next;
  logic        tick;
  logic        act_seen_reg, act_seen_next;
  logic        blink_lvl_reg, blink_lvl_next;
  logic        ind_out_next;
  logic        ind_oe_n_next;
  logic [1:0]  ind_field;

  // Pin and link inputs pass two flip-flops
  lsfp_sync2 #(.WIDTH(3)) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({ind_pin_in, fiber_pin_in, act_toggle_w}),
    .q     ({ind_s, fiber_s, act_s})
  );

  // Receive pins on the link clock
  lsfp_rx_link u_rx (
    .rx_clk     (rx_clk),
    .hresetn    (hresetn),
    .rmii_mode  (rmii_mode),
    .core_valid (core_valid),
    .core_data  (core_data),
    .rxd        (rxd),
    .rx_dv      (rx_dv),
    .act_toggle (act_toggle_w)
  );

  assign rmii_mode = vendor_reg[lsfp_pkg::RMII_MODE_BIT];
  assign ind_field = vendor_reg[lsfp_pkg::IND_FIELD_HI:lsfp_pkg::IND_FIELD_LO];
  assign act_evt   = act_s ^ act_d_reg;
  assign addr_ok   = hsel & hready & htrans[1] & (hsize == 3'h2);
  assign rd_idx    = reg_index(haddr);
  assign capture   = (phase_reg == PH_STRAP) && (settle_reg == 2'(lsfp_pkg::STRAP_SETTLE_CYC - 1));
  assign sig_det   = fiber_mode_reg & fiber_s;
  assign tick      = (blink_cnt_reg == BLINK_LAST);

  // Bus slave: zero wait, read data fetched in the address phase
  always_comb
  begin
    wr_pend_next = addr_ok & hwrite;
    wr_idx_next  = addr_ok ? rd_idx : wr_idx_reg;
    hrdata_next  = hrdata;
    basic_next   = basic_reg;
    vendor_next  = vendor_reg;
    if (addr_ok && !hwrite)
    begin
      case (rd_idx)
        lsfp_pkg::BASIC_CTRL_IDX:  hrdata_next = {16'h0, basic_reg};
        lsfp_pkg::VENDOR_CTRL_IDX: hrdata_next = {16'h0, vendor_reg};
        lsfp_pkg::STRAP_STAT_IDX:
          hrdata_next = {27'h0, act_seen_reg, phase_reg == PH_RUN,
                         sig_det, fef_en_reg, fiber_mode_reg};
        default: hrdata_next = 32'h0;
      endcase
    end
    if (wr_pend_reg && wr_idx_reg == lsfp_pkg::BASIC_CTRL_IDX)
      basic_next = hwdata[15:0];
    if (wr_pend_reg && wr_idx_reg == lsfp_pkg::VENDOR_CTRL_IDX)
      vendor_next = hwdata[15:0];
    // Strap load wins over a software write in the same cycle
    if (capture && !fiber_s)
      basic_next[lsfp_pkg::SPEED_SEL_BIT] = ind_s;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h0;
      hrdata      <= 32'h0;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      basic_reg   <= lsfp_pkg::BASIC_CTRL_RST;
      vendor_reg  <= lsfp_pkg::VENDOR_CTRL_RST;
    end
    else
    begin
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg  <= wr_idx_next;
      hrdata      <= hrdata_next;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      basic_reg   <= basic_next;
      vendor_reg  <= vendor_next;
    end
  end

  // Strap phase: pin released, settle, then sample and drive
  always_comb
  begin
    phase_next      = phase_reg;
    settle_next     = settle_reg;
    fiber_mode_next = fiber_mode_reg;
    fef_en_next     = fef_en_reg;
    case (phase_reg)
      PH_STRAP:
      begin
        settle_next = settle_reg + 2'h1;
        if (capture)
        begin
          phase_next      = PH_RUN;
          fiber_mode_next = fiber_s;
          if (fiber_s)
            fef_en_next = ind_s;
        end
      end
      PH_RUN: phase_next = PH_RUN;
      default: phase_next = PH_STRAP;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_reg      <= PH_STRAP;
      settle_reg     <= 2'h0;
      fiber_mode_reg <= 1'b0;
      fef_en_reg     <= 1'b1;
    end
    else
    begin
      phase_reg      <= phase_next;
      settle_reg     <= settle_next;
      fiber_mode_reg <= fiber_mode_next;
      fef_en_reg     <= fef_en_next;
    end
  end

  // Blink timer and activity memory; a new event wins over the clear
  always_comb
  begin
    blink_cnt_next = tick ? '0 : blink_cnt_reg + CW'(1);
    act_seen_next  = act_evt | (act_seen_reg & ~tick);
    blink_lvl_next = blink_lvl_reg;
    if (tick)
      blink_lvl_next = (act_seen_reg | act_evt) ? ~blink_lvl_reg : 1'b1;
  end

  // Indicator pin function
  always_comb
  begin
    ind_oe_n_next = (phase_next != PH_RUN);
    ind_out_next  = 1'b1;
    if (phase_reg == PH_RUN)
    begin
      case (ind_field)
        IND_RATE_C:    ind_out_next = ~basic_reg[lsfp_pkg::SPEED_SEL_BIT];
        IND_TRAFFIC_C: ind_out_next = blink_lvl_reg;
        default:       ind_out_next = 1'b1;
      endcase
    end
  end

  // Blink, activity edge and pin registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      blink_cnt_reg <= '0;
      act_seen_reg  <= 1'b0;
      blink_lvl_reg <= 1'b1;
      act_d_reg     <= 1'b0;
      ind_pin_out   <= 1'b1;
      ind_pin_oe_n  <= 1'b1;
    end
    else
    begin
      blink_cnt_reg <= blink_cnt_next;
      act_seen_reg  <= act_seen_next;
      blink_lvl_reg <= blink_lvl_next;
      act_d_reg     <= act_s;
      ind_pin_out   <= ind_out_next;
      ind_pin_oe_n  <= ind_oe_n_next;
    end
  end

  strap_input_a: assert property (@(posedge hclk) disable iff (!hresetn)
    phase_reg == PH_STRAP |-> ind_pin_oe_n) else $error("pin driven during strap");
  run_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
    phase_reg == PH_RUN |-> !ind_pin_oe_n) else $error("pin not driven after strap");
  speed_strap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    capture && !fiber_s |=> basic_reg[lsfp_pkg::SPEED_SEL_BIT] == $past(ind_s)
      && fiber_mode_reg == 1'b0)
    else $error("speed strap not loaded");
  fef_strap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    capture && fiber_s |=> fef_en_reg == $past(ind_s) && fiber_mode_reg)
    else $error("fault strap not loaded");
  rate_show_a: assert property (@(posedge hclk) disable iff (!hresetn)
    phase_reg == PH_RUN && ind_field == IND_RATE_C
      |=> ind_pin_out == !$past(basic_reg[lsfp_pkg::SPEED_SEL_BIT]))
    else $error("rate indicator wrong");
  reserved_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    phase_reg == PH_RUN && ind_field[1] |=> ind_pin_out)
    else $error("reserved code not off");
  copper_nosd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !fiber_mode_reg |-> !sig_det) else $error("signal detect in copper mode");
  idle_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tick && !act_seen_reg && !act_evt |=> blink_lvl_reg) else $error("idle not high");
  blink_flip_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tick && act_seen_reg |=> blink_lvl_reg != $past(blink_lvl_reg))
    else $error("no toggle with activity");
  bus_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp) else $error("bus not ready or not okay");
  rdata_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(addr_ok && !hwrite) |=> $stable(hrdata)) else $error("read data not held");
  run_stays_a: assert property (@(posedge hclk) disable iff (!hresetn)
    phase_reg == PH_RUN |=> phase_reg == PH_RUN) else $error("strap phase reentered");
endmodule // lsfp_top
`default_nettype wire

// *** testbench/lsfp_mac_model.sv ***
/*
  Receiving MAC model: collects the receive pins into a frame word.
  Assumes rxd and rx_dv change just after a rising rx_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module lsfp_mac_model (
  // Link clock
  input  wire logic        rx_clk,
  // Receive pins
  input  wire logic [3:0]  rxd,
  input  wire logic        rx_dv,
  // Collected frame and unit count
  output logic      [15:0] frame,
  output logic      [3:0]  units
);
  logic        dv_prev   = 1'b0;
  logic [15:0] frame_reg = 16'h0000;
  logic [3:0]  units_reg = 4'h0;

  assign frame = frame_reg;
  assign units = units_reg;

  // Data counts only while valid; a new frame restarts the word
  always @(posedge rx_clk)
  begin
    dv_prev <= rx_dv;
    if (rx_dv)
    begin
      frame_reg <= dv_prev ? {frame_reg[11:0], rxd} : {12'h000, rxd};
      units_reg <= dv_prev ? units_reg + 4'h1 : 4'h1;
    end
  end
endmodule // lsfp_mac_model
`default_nettype wire

// *** testbench/lsfp_top_test.sv ***
/*
  Testbench: straps through resets, registers over AHB-Lite,
  indicator functions and receive frames into a MAC model.
  Assumes the strap pin pull resistor level is set by strap_lvl.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
  $display("Error at %0t got %h expected %h", $time, (a), (e)); end end
module lsfp_top_test;
  localparam int unsigned BLINK = 8;
  logic        hclk = 1'b0;
  logic        rx_clk = 1'b0;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        ind_pin_out;
  logic        ind_pin_oe_n;
  logic        strap_lvl;
  logic        fiber_pin_in;
  logic        core_valid;
  logic [3:0]  core_data;
  logic [3:0]  rxd;
  logic        rx_dv;
  logic [15:0] frame;
  logic [3:0]  units;
  logic [31:0] rdata;
  int          mismatches;
  int          checks_done;
  wire logic   ind_pin_in;
  // Expected speed word and status low bits per strap case
  logic [31:0] tbl_bc [4] = '{32'h2000, 32'h2000, 32'h0, 32'h2000};
  logic [3:0]  tbl_st [4] = '{4'hd, 4'hf, 4'ha, 4'ha};

  // Pull resistor while released, driven level afterwards
  assign ind_pin_in = ind_pin_oe_n ? strap_lvl : ind_pin_out;

  // Bus clock 100 ns, link clock 12 ns
  always #50 hclk = ~hclk;
  always #6 rx_clk = ~rx_clk;

  lsfp_top #(.BLINK_CYC(BLINK)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ind_pin_in(ind_pin_in), .ind_pin_out(ind_pin_out), .ind_pin_oe_n(ind_pin_oe_n),
    .fiber_pin_in(fiber_pin_in), .rx_clk(rx_clk), .core_valid(core_valid),
    .core_data(core_data), .rxd(rxd), .rx_dv(rx_dv)
  );

  lsfp_mac_model u_mac (
    .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .frame(frame), .units(units)
  );

  // Verdict and end of run
  task conclude;
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Waits for hready high at a rising edge, bounded
  task wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      mismatches++;
      conclude();
    end
  endtask

  // One single word transfer; read data lands in rdata
  task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rdata = hrdata;
  endtask

  // Chip reset with strap levels held across the sample point
  task do_reset(input logic f, input logic s);
    hresetn      <= 1'b0;
    fiber_pin_in <= f;
    strap_lvl    <= s;
    repeat (4) @(posedge hclk);
    `CHK({ind_pin_oe_n, ind_pin_out, rx_dv}, 3'h6)
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    `CHK(ind_pin_oe_n, 1'b0)
  endtask

  // Four core units on the link clock, then idle
  task send(input logic [15:0] d);
    for (int i = 3; i >= 0; i--)
    begin
      @(posedge rx_clk);
      core_valid <= 1'b1;
      core_data  <= d[4*i +: 4];
    end
    @(posedge rx_clk);
    core_valid <= 1'b0;
    core_data  <= 4'h0;
    repeat (4) @(posedge rx_clk);
  endtask

  // Waits a bounded time for the indicator level
  task wait_pin(input logic v);
    int n;
    n = 0;
    while (ind_pin_out !== v && n < 40)
    begin
      @(posedge hclk);
      n++;
    end
    `CHK(ind_pin_out, v)
    if (ind_pin_out !== v)
      conclude();
  endtask

  // Main sequence
  initial
  begin
    mismatches = 0;
    checks_done = 0;
    hsel = 1'b1;
    hsize = 3'h2;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    core_valid = 1'b0;
    core_data = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      do_reset(i < 2, i[0]);
      xfer(1'b0, 32'h0, 32'h0);
      `CHK(rdata, tbl_bc[i])
      xfer(1'b0, 32'h7c, 32'h0);
      `CHK(rdata[3:0], tbl_st[i])
      if (i < 2)
      begin
        fiber_pin_in <= 1'b0;
        repeat (4) @(posedge hclk);
        xfer(1'b0, 32'h7c, 32'h0);
        `CHK(rdata[3:0], tbl_st[i] ^ 4'h4)
      end
    end
    // A half-word write is refused and leaves the register alone
    hsize <= 3'h1;
    xfer(1'b1, 32'h78, 32'hc000);
    hsize <= 3'h2;
    xfer(1'b0, 32'h78, 32'h0);
    `CHK(rdata, 32'h0)
    xfer(1'b0, 32'h40, 32'h0);
    `CHK(rdata, 32'h0)
    `CHK(ind_pin_out, 1'b0)
    xfer(1'b1, 32'h0, 32'h0);
    repeat (3) @(posedge hclk);
    `CHK(ind_pin_out, 1'b1)
    xfer(1'b1, 32'h0, 32'h2000);
    for (int c = 3; c > 1; c--)
    begin
      xfer(1'b1, 32'h78, {16'h0, c[1:0], 14'h0});
      repeat (3) @(posedge hclk);
      `CHK(ind_pin_out, 1'b1)
    end
    xfer(1'b1, 32'h78, 32'h0);
    send(16'h5a3c);
    `CHK(frame, 16'h5a3c)
    `CHK({units, rx_dv, rxd}, 9'h080)
    xfer(1'b1, 32'h78, 32'h1);
    repeat (4) @(posedge hclk);
    // Upper core bits are dropped on the two-bit bus
    send(16'h1234);
    `CHK(frame, 16'h1230)
    `CHK(units, 4'h4)
    xfer(1'b1, 32'h78, 32'h4001);
    repeat (40) @(posedge hclk);
    `CHK(ind_pin_out, 1'b1)
    send(16'h1111);
    wait_pin(1'b0);
    wait_pin(1'b1);
    repeat (20) @(posedge hclk);
    `CHK(ind_pin_out, 1'b1)
    `CHK(hresp, 1'b0)
    conclude();
  end
endmodule // lsfp_top_test
`default_nettype wire
